/* File: test/fgs_scanner_model.sv */
/*
 Scanner side model: writes header words, reads the status image.
 Driven by tb_top through its tasks; inputs change 1 ns after clk.
*/
`timescale 1ns/1ps
module fgs_scanner_model (
   // Clock
   input  wire logic        clk,
   // Header words
   output fgs_pkg::fgs_cmd_t cmd,
   output logic             cmd_wr,
   // Status read port
   output logic             rd_req,
   output logic [3:0]       rd_addr,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_valid
);
   // Sizes it would request: empty tables plus header bytes
   localparam int unsigned OUT_CONN_BYTES = 4;  // At most 496
   localparam int unsigned IN_CONN_BYTES  = 4;  // At most 500
   // No configuration block is ever sent, size zero
   initial begin
      cmd    = 64'h0;
      cmd_wr = 1'b0;
      rd_req = 1'b0;
      rd_addr = 4'hF;
   end
   // One header write; run flags come from the given words
   task automatic write_cmd(input logic [31:0] cw, input logic [31:0] rw);
      @(posedge clk);
      #1;
      cmd    = {rw, cw};
      cmd_wr = 1'b1;
      @(posedge clk);
      #1;
      cmd_wr = 1'b0;
      cmd    = fgs_pkg::fgs_cmd_t'(~cmd); // Released words show junk
   endtask
   // One byte of the status connection
   task automatic read_byte(input logic [3:0] a, output logic [7:0] d,
                            output logic ok);
      @(posedge clk);
      #1;
      rd_req  = 1'b1;
      rd_addr = a;
      @(posedge clk);
      #1;
      rd_req  = 1'b0;
      rd_addr = ~a;
      ok      = rd_valid === 1'b1;
      d       = rd_data;
   endtask
endmodule

/* File: test/fgs_status_bank_assertions.sv */
/*
 Port checker for the gateway status bank.
 Bound from tb_top onto fgs_status_bank; one clock, reset rstn.
*/
`timescale 1ns/1ps
module fgs_status_bank_assertions #(
   parameter int unsigned REFRESH_CYCLES = 16
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rstn,
   // Header and read port
   input wire logic              cmd_wr,
   input wire fgs_pkg::fgs_cmd_t cmd,
   input wire logic              rd_req,
   input wire logic [3:0]        rd_addr,
   input wire logic [7:0]        rd_data,
   input wire logic              rd_valid,
   // Summary outputs
   input wire logic              run_mode,
   input wire logic              refresh_tick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [15:0] gap_r;
   logic        seen_r;
   logic        run_req;
   // Requested run mode of this header write
   assign run_req = cmd.cmd_word[0] & cmd.runidle_word[0];
   // Cycles since the last refresh pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_r  <= 16'h0000;
         seen_r <= 1'b0;
      end else begin
         gap_r  <= refresh_tick ? 16'h0000 : gap_r + 16'h0001;
         seen_r <= seen_r | refresh_tick;
      end
   end
   chk_read_answer: assert property (rd_req |=> rd_valid)
      else $error("read not answered");
   chk_no_stray: assert property (!rd_req |=> !rd_valid)
      else $error("valid without request");
   chk_data_holds: assert property (!rd_req |=> $stable(rd_data))
      else $error("read data moved");
   chk_spare_zero: assert property (rd_req && rd_addr >= 4'hA
      |=> rd_data == 8'h00) else $error("spare byte not zero");
   chk_state_low: assert property (rd_req && rd_addr == 4'h0
      |=> rd_data inside {8'h00, 8'h01, 8'h02}) else $error("state low");
   chk_state_high: assert property (rd_req && rd_addr == 4'h1
      |=> rd_data inside {8'h00, 8'h80}) else $error("state high");
   chk_fault_unused: assert property (rd_req && rd_addr == 4'h3
      |=> rd_data == 8'h00) else $error("unused fault bits set");
   chk_run_and: assert property (cmd_wr
      |=> run_mode == $past(run_req)) else $error("run mode wrong");
   chk_run_holds: assert property (!cmd_wr |=> $stable(run_mode))
      else $error("run mode moved");
   chk_tick_gap: assert property (refresh_tick && seen_r
      |-> gap_r == REFRESH_CYCLES - 1) else $error("refresh period");
   chk_tick_single: assert property (refresh_tick |=> !refresh_tick)
      else $error("refresh pulse too long");
   cov_tick: cover property (refresh_tick);
   cov_clear: cover property (cmd_wr && cmd.cmd_word[1]);
   cov_state: cover property (rd_req && rd_addr == 4'h1);
endmodule

/* File: test/tb_top.sv */
/*
 Testbench for the gateway status bank.
 Uses a short refresh period; the scanner model drives header and reads.
*/
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned RC = 16;
   logic                   clk;
   logic                   rstn;
   logic                   claim_start;
   logic                   claim_ok;
   logic                   claim_fail;
   logic                   can_error_evt;
   fgs_pkg::fgs_fault_in_t fault_in;
   fgs_pkg::fgs_cmd_t      cmd;
   logic                   cmd_wr;
   logic                   rd_req;
   logic [3:0]             rd_addr;
   logic [7:0]             rd_data;
   logic                   rd_valid;
   logic                   run_mode;
   logic [31:0]            in_status;
   logic                   refresh_tick;
   int                     fails;
   int                     n_compared;

   fgs_status_bank #(.REFRESH_CYCLES(RC)) uut (.clk(clk), .rstn(rstn),
      .claim_start(claim_start), .claim_ok(claim_ok),
      .claim_fail(claim_fail), .fault_in(fault_in),
      .can_error_evt(can_error_evt), .cmd_wr(cmd_wr), .cmd(cmd),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .run_mode(run_mode), .in_status(in_status),
      .refresh_tick(refresh_tick));
   fgs_scanner_model scn (.clk(clk), .cmd(cmd), .cmd_wr(cmd_wr),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid));

   // Clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Verdict and end of run
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Word read, low byte at the even offset
   task automatic rd_word(input logic [3:0] a, output logic [15:0] w);
      logic [7:0] lo;
      logic [7:0] hi;
      logic       v0;
      logic       v1;
      scn.read_byte(a, lo, v0);
      scn.read_byte(a + 4'h1, hi, v1);
      w = {hi, lo};
      cmp16({15'h0, v0 & v1}, 16'h0001);
   endtask
   // Whole image, offsets 0 to 14
   task automatic chk_image(input logic [15:0] e [8]);
      logic [15:0] w;
      for (int i = 0; i < 8; i++) begin
         rd_word(4'(2 * i), w);
         cmp16(w, e[i]);
      end
   endtask
   // Bounded wait for a refresh, then one more edge
   task automatic wait_tick();
      int k;
      k = 0;
      while (refresh_tick !== 1'b1 && k < 4 * RC) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 4 * RC) begin
         fails++;
         test_done();
      end else begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic claim(input logic [2:0] p);
      {claim_start, claim_ok, claim_fail} = p;
      @(posedge clk);
      #1;
      {claim_start, claim_ok, claim_fail} = 3'b000;
   endtask
   // Image empty until the first refresh, then initializing
   task automatic t_image();
      logic [15:0] w;
      rd_word(4'h0, w);
      cmp16(w, 16'h0000);
      wait_tick();
      rd_word(4'h0, w);
      cmp16(w, 16'h8002);
   endtask
   // Claim outcomes drive state and fault bit 0
   task automatic t_claims();
      logic [2:0]  p [8] = '{3'b010, 3'b100, 3'b001, 3'b100,
                             3'b010, 3'b001, 3'b100, 3'b010};
      logic [15:0] s [8] = '{16'h8001, 16'h8002, 16'h8000, 16'h8002,
                             16'h8001, 16'h8000, 16'h8002, 16'h8001};
      logic        b [8] = '{1'b0, 1'b0, 1'b1, 1'b1,
                             1'b0, 1'b1, 1'b1, 1'b0};
      logic [15:0] w;
      for (int i = 0; i < 8; i++) begin
         wait_tick();
         claim(p[i]);
         wait_tick();
         rd_word(4'h0, w);
         cmp16(w, s[i]);
         rd_word(4'h2, w);
         cmp16(w, {15'h0, b[i]});
         cmp16(in_status[15:0],
               {13'h0, b[i], s[i] == 16'h8001, 1'b0});
      end
   endtask
   // One pulse per fault, three errors; flags must stick
   task automatic t_faults();
      logic [15:0] e [8] = '{16'h8000, 16'h007E, 16'h0003, 16'h0001,
                             16'h0001, 16'h0000, 16'h0000, 16'h0000};
      wait_tick();
      for (int i = 0; i < 6; i++) begin
         fault_in = fgs_pkg::fgs_fault_in_t'(6'h01 << i);
         @(posedge clk);
         #1;
      end
      fault_in      = 6'h00;
      can_error_evt = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      can_error_evt = 1'b0;
      wait_tick();
      chk_image(e);
   endtask
   // Fault reset clears sticky flags and counters
   task automatic t_clear();
      logic [15:0] e [8] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000};
      scn.write_cmd(32'h0000_0002, 32'h0000_0000);
      wait_tick();
      chk_image(e);
   endtask
   // Run mode needs both flags; unused bits ignored
   task automatic t_run();
      for (int i = 0; i < 4; i++) begin
         scn.write_cmd(32'h0000_0008 | 32'(i & 1),
                       32'hFFFF_FFFE | 32'(i >> 1));
         cmp16({15'h0, run_mode}, {15'h0, i == 3});
         @(posedge clk);
         #1;
         cmp16(in_status[15:0], {15'h0, i == 3});
      end
   endtask
   // Error counter stops at its top value
   task automatic t_saturate();
      logic [15:0] w;
      can_error_evt = 1'b1;
      repeat (65540) @(posedge clk);
      #1;
      can_error_evt = 1'b0;
      wait_tick();
      rd_word(4'h4, w);
      cmp16(w, 16'hFFFF);
   endtask
   // Reset, then scenarios in order
   initial begin
      fails         = 0;
      n_compared    = 0;
      rstn          = 1'b0;
      claim_start   = 1'b0;
      claim_ok      = 1'b0;
      claim_fail    = 1'b0;
      can_error_evt = 1'b0;
      fault_in      = 6'h00;
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_image();
      t_claims();
      t_faults();
      t_clear();
      t_run();
      t_saturate();
      test_done();
   end
endmodule

bind fgs_status_bank fgs_status_bank_assertions #(
   .REFRESH_CYCLES(REFRESH_CYCLES)
) chk (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd(cmd),
   .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
   .rd_valid(rd_valid), .run_mode(run_mode),
   .refresh_tick(refresh_tick));

/* File: verilog/fgs_pkg.sv */
/*
 Constants and carrier types for the gateway status bank: assembly
 offsets, fault bit positions, state codes, command bits and the
 refresh timing. Assumes a single 25 MHz clock domain.
*/
// How it works
// - All status fields are copied to the readable image once per second.
// - Multi-byte fields are read little endian, low byte at lower offset.
// - State word: 0x8000 offline, 0x8001 online, 0x8002 initializing.
// - Offset two holds the 16-bit fault word, one flag per bit.
// - Offset four counts CAN errors, zeroed by the fault reset bit.
// - Offset six counts bus-off events, zeroed by the fault reset bit.
// - Offset eight counts receive overruns, zeroed by the fault reset bit.
// - Status block is 12 bytes; the word at offset 10 is reserved.
// - Fault bit 0 shows a failed address claim.
// - Fault bit 1 shows a CAN error warning.
// - Fault bit 2 shows bus-off.
// - Fault bit 3 shows a receive overrun.
// - Fault bit 4 shows a multi-packet transport message error.
// - Fault bit 5 shows receive queue overflow.
// - Fault bit 6 shows transmit queue overflow; bits 7 to 15 unused.
// - Fault bits 1 to 6 stay set until a fault reset command.
// - No configuration block; configuration instance is ignored, size zero.
// - Operate only when host run and controller run flags are both set.
package fgs_pkg;

   // Clock and refresh timing
   localparam int unsigned CLK_PERIOD_NS     = 40;
   localparam int unsigned REFRESH_PERIOD_MS = 1000;
   localparam int unsigned REFRESH_CYCLES    =
      (REFRESH_PERIOD_MS * 1000) / CLK_PERIOD_NS * 1000;

   // Status assembly layout, byte offsets
   localparam int unsigned STATUS_BYTES      = 12;
   localparam int unsigned STATUS_WORDS      = 6;
   localparam logic [3:0]  OFS_STATE         = 4'h0;
   localparam logic [3:0]  OFS_FAULTS        = 4'h2;
   localparam logic [3:0]  OFS_ERR_CNT       = 4'h4;
   localparam logic [3:0]  OFS_BUSOFF_CNT    = 4'h6;
   localparam logic [3:0]  OFS_OVERRUN_CNT   = 4'h8;
   localparam logic [3:0]  OFS_SPARE         = 4'hA;
   localparam logic [3:0]  OFS_END           = 4'hC;

   // Interface state codes
   localparam logic [15:0] STATE_OFFLINE     = 16'h8000;
   localparam logic [15:0] STATE_ONLINE      = 16'h8001;
   localparam logic [15:0] STATE_INIT        = 16'h8002;

   // Fault word bit positions
   localparam int unsigned FB_CLAIM_FAIL     = 0;
   localparam int unsigned FB_WARNING        = 1;
   localparam int unsigned FB_BUSOFF         = 2;
   localparam int unsigned FB_OVERRUN        = 3;
   localparam int unsigned FB_MULTIPACKET    = 4;
   localparam int unsigned FB_RX_QUEUE       = 5;
   localparam int unsigned FB_TX_QUEUE       = 6;
   localparam int unsigned FB_STICKY_LO      = 1;
   localparam int unsigned FB_STICKY_HI      = 6;

   // Command and run/idle register bits
   localparam int unsigned CMD_LOCAL_RUN     = 0;
   localparam int unsigned CMD_RESET_FAULTS  = 1;
   localparam int unsigned RUNIDLE_SYS_RUN   = 0;

   // Input status register bits
   localparam int unsigned IST_RUN           = 0;
   localparam int unsigned IST_ONLINE        = 1;
   localparam int unsigned IST_FAULT         = 2;

   // Reset values and limits
   localparam logic [15:0] WORD_RESET        = 16'h0000;
   localparam logic [15:0] CNT_MAX           = 16'hFFFF;
   localparam logic [7:0]  BYTE_ZERO         = 8'h00;

   // Fault condition inputs, each a level or pulse from the CAN side
   typedef struct packed {
      logic tx_queue_overflow;
      logic rx_queue_overflow;
      logic multipacket_error;
      logic overrun;
      logic busoff;
      logic warning;
   } fgs_fault_in_t;

   // One write of the output connection header words
   typedef struct packed {
      logic [31:0] runidle_word;
      logic [31:0] cmd_word;
   } fgs_cmd_t;

endpackage

/* File: verilog/fgs_sat_counter.sv */
/*
 Sixteen-bit saturating event counter with synchronous clear.
 Assumes inc and clr are one-cycle pulses in the clk domain.
*/
`timescale 1ns/1ps
module fgs_sat_counter (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Control
   input  wire logic        inc,
   input  wire logic        clr,
   // Count
   output logic [15:0]      count
);

   logic [15:0] count_r;

   // Clear wins over old value, a same-cycle event still counts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= fgs_pkg::WORD_RESET;
      end else if (clr) begin
         count_r <= inc ? 16'h0001 : fgs_pkg::WORD_RESET;
      end else if (inc && count_r != fgs_pkg::CNT_MAX) begin
         count_r <= count_r + 16'h0001;  // Holds at maximum
      end
   end

   assign count = count_r;

endmodule

/* File: verilog/fgs_status_bank.sv */
/*
 Diagnostic status bank of the field bus gateway. Keeps the vehicle
 network interface state, the fault word and three CAN counters live,
 copies them into a 12-byte status image once a second and serves that
 image byte by byte to the connection side. Also decodes the command
 and run/idle header words into the run mode and the fault reset.
 Assumes all inputs are synchronous to clk; event inputs from the CAN
 side may be levels or pulses; the bus-off and overrun counters count rising edges, the error counter every high cycle.
 The refresh period is a parameter so a
 test may shorten it. Reads see only the
 image, so any change shows at the next
 strobe.
*/
`timescale 1ns/1ps
module fgs_status_bank #(
   parameter int unsigned REFRESH_CYCLES = fgs_pkg::REFRESH_CYCLES
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rstn,
   // Address claim progress from the protocol stack
   input  wire logic                  claim_start,
   input  wire logic                  claim_ok,
   input  wire logic                  claim_fail,
   // CAN side fault conditions
   input  wire fgs_pkg::fgs_fault_in_t fault_in,
   input  wire logic                  can_error_evt,
   // Output connection header words
   input  wire logic                  cmd_wr,
   input  wire fgs_pkg::fgs_cmd_t     cmd,
   // Status image read port
   input  wire logic                  rd_req,
   input  wire logic [3:0]            rd_addr,
   output logic [7:0]                 rd_data,
   output logic                       rd_valid,
   // Summary outputs
   output logic                       run_mode,
   output logic [31:0]                in_status,
   output logic                       refresh_tick
);

   // Interface state machine
   // Only the reported word has fixed codes
   typedef enum logic [1:0] {
      ST_INIT,
      ST_ONLINE,
      ST_OFFLINE
   } fgs_state_t;

   fgs_state_t         state_r;
   fgs_state_t         state_nxt;

   // Live status and the once-a-second image
   // Present values in live, read ones in snap_r
   logic               claim_fail_r;
   logic [5:0]         sticky_r;
   fgs_pkg::fgs_fault_in_t fault_prev_r;
   logic [15:0]        fault_word;
   logic [15:0]        state_code;
   logic [15:0]        err_cnt;
   logic [15:0]        busoff_cnt;
   logic [15:0]        overrun_cnt;
   logic [15:0]        live [fgs_pkg::STATUS_WORDS];
   logic [15:0]        snap_r [fgs_pkg::STATUS_WORDS];
   logic               tick;

   // Command decode
   logic               local_run_r;
   logic               sys_run_r;
   logic               fault_clr;
   logic               busoff_rise;
   logic               overrun_rise;

   // Read port
   // Word index and the selected word
   logic [7:0]         rd_data_r;
   logic               rd_valid_r;
   logic [31:0]        in_status_r;
   logic [2:0]         rd_word;
   logic [15:0]        rd_sel;

   // Once-a-second refresh strobe
   // The image moves only on this strobe,
   // so every read sees one coherent set
   fgs_tick_gen #(
      .PERIOD (REFRESH_CYCLES)
   ) u_tick (
      .clk    (clk),
      .rstn   (rstn),
      .tick   (tick)
   );

   // Fault reset request: a write with the reset bit set to one
   // Acts on every such write, not on a
   // change of the bit
   assign fault_clr = cmd_wr &&
      cmd.cmd_word[fgs_pkg::CMD_RESET_FAULTS];

   // Run flags held from the last header write
   // Other header bits have no effect
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         local_run_r <= 1'b0;
         sys_run_r   <= 1'b0;
      end else if (cmd_wr) begin
         local_run_r <= cmd.cmd_word[fgs_pkg::CMD_LOCAL_RUN];
         sys_run_r   <= cmd.runidle_word[fgs_pkg::RUNIDLE_SYS_RUN];
      end
   end

   // Operate only with both run flags, else paused
   // Paused until both are written as one
   assign run_mode = local_run_r & sys_run_r;

   // Interface state transitions
   // Claim failure beats success in one
   // cycle; bus-off drops an online link
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT: begin
            if (claim_fail) begin
               state_nxt = ST_OFFLINE;
            end else if (claim_ok) begin
               state_nxt = ST_ONLINE;
            end
         end
         ST_ONLINE: begin
            if (claim_start) begin
               state_nxt = ST_INIT;
            end else if (fault_in.busoff || claim_fail) begin
               state_nxt = ST_OFFLINE;
            end
         end
         ST_OFFLINE: begin
            if (claim_start) begin
               state_nxt = ST_INIT;
            end
         end
         default: begin
            state_nxt = ST_INIT;
         end
      endcase
   end

   // State register; starts initializing after reset
   // Image reads zero until the first strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_INIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // State code reported in the first word
   // Default only guards illegal encodings
   always_comb begin
      case (state_r)
         ST_ONLINE:  state_code = fgs_pkg::STATE_ONLINE;
         ST_OFFLINE: state_code = fgs_pkg::STATE_OFFLINE;
         ST_INIT:    state_code = fgs_pkg::STATE_INIT;
         default:    state_code = fgs_pkg::STATE_OFFLINE;
      endcase
   end

   // Claim failure flag follows the present claim outcome
   // Not sticky; fault reset leaves it,
   // a later good claim clears it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         claim_fail_r <= 1'b0;
      end else if (claim_fail) begin
         claim_fail_r <= 1'b1;
      end else if (claim_ok) begin
         claim_fail_r <= 1'b0;
      end
   end

   // Sticky fault bits 1 to 6; a new fault beats the clear
   // so no event is lost between the clear
   // and the next strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sticky_r <= 6'h00;
      end else if (fault_clr) begin
         sticky_r <= fault_in;
      end else begin
         sticky_r <= sticky_r | fault_in;
      end
   end

   // Fault word assembly, unused upper bits read zero
   // Bit 0 from the claim flag, 1 to 6 sticky
   always_comb begin
      fault_word = fgs_pkg::WORD_RESET;
      fault_word[fgs_pkg::FB_CLAIM_FAIL] = claim_fail_r;
      fault_word[fgs_pkg::FB_WARNING]    = sticky_r[0];
      fault_word[fgs_pkg::FB_BUSOFF]     = sticky_r[1];
      fault_word[fgs_pkg::FB_OVERRUN]    = sticky_r[2];
      fault_word[fgs_pkg::FB_MULTIPACKET] = sticky_r[3];
      fault_word[fgs_pkg::FB_RX_QUEUE]   = sticky_r[4];
      fault_word[fgs_pkg::FB_TX_QUEUE]   = sticky_r[5];
   end

   // Edge history so a held level counts once
   // Bus-off and overrun are levels on the
   // CAN side; one event is one count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fault_prev_r <= '0;
      end else begin
         fault_prev_r <= fault_in;
      end
   end

   // Rising edges of the two counted levels
   assign busoff_rise  = fault_in.busoff  & ~fault_prev_r.busoff;
   assign overrun_rise = fault_in.overrun & ~fault_prev_r.overrun;

   // Accumulated CAN errors
   // Each cycle with the event high counts
   fgs_sat_counter u_err_cnt (
      .clk    (clk),
      .rstn   (rstn),
      .inc    (can_error_evt),
      .clr    (fault_clr),
      .count  (err_cnt)
   );

   // Bus-off events
   // One count per entry into bus-off
   fgs_sat_counter u_busoff_cnt (
      .clk    (clk),
      .rstn   (rstn),
      .inc    (busoff_rise),
      .clr    (fault_clr),
      .count  (busoff_cnt)
   );

   // Receive overrun events
   // One count per overrun seen
   fgs_sat_counter u_overrun_cnt (
      .clk    (clk),
      .rstn   (rstn),
      .inc    (overrun_rise),
      .clr    (fault_clr),
      .count  (overrun_cnt)
   );

   // Live image in assembly word order
   // Word n stands at byte offset 2n
   // The reserved word is tied to zero
   assign live[0] = state_code;        // Offset 0
   assign live[1] = fault_word;        // Offset 2
   assign live[2] = err_cnt;           // Offset 4
   assign live[3] = busoff_cnt;        // Offset 6
   assign live[4] = overrun_cnt;       // Offset 8
   assign live[5] = fgs_pkg::WORD_RESET;  // Reserved word

   // Copy every word on the refresh strobe only
   // All words take one edge, so the block
   // always belongs to one instant
   genvar gw;
   generate
      for (gw = 0; gw < fgs_pkg::STATUS_WORDS; gw++) begin : g_snap
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               snap_r[gw] <= fgs_pkg::WORD_RESET;
            end else if (tick) begin
               snap_r[gw] <= live[gw];
            end
         end
      end
   endgenerate

   // Byte lookup: word index from upper bits, low byte first
   assign rd_word = rd_addr[3:1];

   // Word select; indexes past the image read zero
   always_comb begin
      case (rd_word)
         3'h0:    rd_sel = snap_r[0];
         3'h1:    rd_sel = snap_r[1];
         3'h2:    rd_sel = snap_r[2];
         3'h3:    rd_sel = snap_r[3];
         3'h4:    rd_sel = snap_r[4];
         3'h5:    rd_sel = snap_r[5];
         default: rd_sel = fgs_pkg::WORD_RESET;  // Offsets 12 to 15
      endcase
   end

   // Registered read answer one cycle after the request
   // Data holds until the next request,
   // so a slow reader may take it later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_r <= fgs_pkg::BYTE_ZERO;
      end else if (rd_req) begin
         if (rd_addr >= fgs_pkg::OFS_END) begin
            rd_data_r <= fgs_pkg::BYTE_ZERO;  // Beyond 12 bytes
         end else if (rd_addr[0]) begin
            rd_data_r <= rd_sel[15:8];  // High byte at odd offset
         end else begin
            rd_data_r <= rd_sel[7:0];   // Low byte at even offset
         end
      end
   end

   // Read valid strobe
   // High for one cycle after each request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= rd_req;
      end
   end

   // No configuration image exists, only the status block is served
   // A configuration number is never decoded
   assign rd_data  = rd_data_r;
   assign rd_valid = rd_valid_r;

   // Input status register: run, online, any fault
   // Lags the live values by one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_status_r <= 32'h00000000;
      end else begin
         in_status_r <= 32'h00000000;
         in_status_r[fgs_pkg::IST_RUN]    <= local_run_r & sys_run_r;
         in_status_r[fgs_pkg::IST_ONLINE] <= (state_r == ST_ONLINE);
         in_status_r[fgs_pkg::IST_FAULT]  <= |fault_word;
      end
   end

   // Summary outputs from their flip-flops
   assign in_status    = in_status_r;
   assign refresh_tick = tick;

endmodule

/* File: verilog/fgs_tick_gen.sv */
/*
 Refresh divider: one-cycle enable pulse every PERIOD clocks.
 Assumes PERIOD of at least 2 and a free running clock.
*/
`timescale 1ns/1ps
module fgs_tick_gen #(
   parameter int unsigned PERIOD = fgs_pkg::REFRESH_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Enable pulse out
   output logic      tick
);

   logic [31:0] cnt_r;
   logic        tick_r;

   // Count up the period and pulse at the wrap
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r  <= 32'h00000000;
         tick_r <= 1'b0;
      end else if (cnt_r == 32'(PERIOD - 1)) begin
         cnt_r  <= 32'h00000000;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h00000001;
         tick_r <= 1'b0;
      end
   end

   assign tick = tick_r;

endmodule
